// ---- common/epim_defs.svh ----
// Constants for the exception priority and interrupt map block.
// Operation
// - Software picks level 0..3 per configurable source.
// - All configurable levels reset to 0.
// - Reset, NMI, Hard Fault outrank everything configurable.
// - Lines 0..31 map to vectors 16..47.
// - SVC 11, Pendable_service_exception 14, System_tick_exception 15, programmable.
// - Brown-out line 0, watchdog line 1.
// - Port B pins 14/15 raise lines 2/3.
// - Port A/B changes line 4; C..F line 5.
// - PWM 0..3 vector 22, 4..7 vector 23.
// - Disabled lines pend; active survives disable.
// - Clear-pending never alters active state.
// - Handler fetched from table at address zero.
`ifndef EPIM_DEFS_SVH
`define EPIM_DEFS_SVH
`define EPIM_NUM_SRC 35
`define EPIM_NUM_IRQ 32
`define EPIM_IRQ_IDX_BASE 3
`define EPIM_IRQ_VEC_BASE 6'h10
`define EPIM_VEC_RESET 6'h01
`define EPIM_VEC_NMI 6'h02
`define EPIM_VEC_HARDFAULT 6'h03
`define EPIM_VEC_SVC 6'h0B
`define EPIM_VEC_PENDABLE_SERVICE_EXCEPTION 6'h0E
`define EPIM_VEC_SYSTEM_TICK_EXCEPTION 6'h0F
`define EPIM_VEC_LAST 6'h2F
`define EPIM_RANK_RESET 3'h0
`define EPIM_RANK_NMI 3'h1
`define EPIM_RANK_HARDFAULT 3'h2
`define EPIM_RANK_CFG_BASE 3'h3
`define EPIM_PRIO_RESET 2'h0
`define EPIM_TABLE_BASE 32'h00000000
`define EPIM_HOLDOFF 2'h2
`define EPIM_LINE_BROWNOUT 0
`define EPIM_LINE_WATCHDOG 1
`define EPIM_LINE_EXT_A 2
`define EPIM_LINE_EXT_B 3
`define EPIM_LINE_PORT_AB 4
`define EPIM_LINE_PORT_CDEF 5
`define EPIM_LINE_PWM_LOW 6
`define EPIM_LINE_PWM_HIGH 7
`define EPIM_LINE_TIMER0 8
`define EPIM_LINE_TIMER1 9
`define EPIM_LINE_TIMER2 10
`endif

// ---- common/epim_pkg.sv ----
// Types shared by the exception priority and interrupt map block.
package epim_pkg;
    typedef logic [5:0]  epim_vector_t;
    typedef logic [5:0]  epim_index_t;
    typedef logic [1:0]  epim_level_t;
    typedef logic [2:0]  epim_rank_t;
    typedef logic [34:0] epim_srcmask_t;
    typedef logic [69:0] epim_prio_t;
endpackage

// ---- design/epim_arbiter.sv ----
// Registered priority arbiter over the configurable sources.
`timescale 1ns/1ps
`include "epim_defs.svh"
module epim_arbiter (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire epim_pkg::epim_srcmask_t cand,
    input  wire epim_pkg::epim_prio_t   prio,
    output logic                        winValid,
    output epim_pkg::epim_index_t       winIndex,
    output epim_pkg::epim_level_t       winLevel
);
    typedef struct packed {
        logic                  valid;
        epim_pkg::epim_index_t index;
        epim_pkg::epim_level_t level;
    } epim_arb_state_t;

    epim_arb_state_t s;
    epim_arb_state_t next_s;

    always_comb
    begin
        next_s = '0;
        for (int i = 0; i < `EPIM_NUM_SRC; i++)
        begin
            if (cand[i] && (!next_s.valid || prio[2*i +: 2] < next_s.level))
            begin
                next_s.valid = 1'b1;
                next_s.index = 6'(i);
                next_s.level = prio[2*i +: 2];
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end

    assign winValid = s.valid;
    assign winIndex = s.index;
    assign winLevel = s.level;

    arb_valid_a: assert property (@(posedge clk) disable iff (reset)
        winValid == (|$past(cand)))
        else $error("arbiter valid does not follow candidates");
endmodule

// ---- design/epim_controller.sv ----
// Exception prioritisation and peripheral interrupt mapping for the core.
`timescale 1ns/1ps
`include "epim_defs.svh"
module epim_controller (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    brownoutIrq,
    input  wire logic                    watchdogIrq,
    input  wire logic                    extPinIrqA,
    input  wire logic                    extPinIrqB,
    input  wire logic [15:0]             portAChange,
    input  wire logic [13:0]             portBChange,
    input  wire logic [15:0]             portCChange,
    input  wire logic [15:0]             portDChange,
    input  wire logic [15:0]             portEChange,
    input  wire logic [3:0]              portFChange,
    input  wire logic [7:0]              pwmChannelIrq,
    input  wire logic                    timerZeroIrq,
    input  wire logic                    timerOneIrq,
    input  wire logic                    timerTwoIrq,
    input  wire logic [20:0]             spareIrq,
    input  wire logic                    nmiReq,
    input  wire logic                    hardFaultReq,
    input  wire logic                    supervisorCallReq,
    input  wire logic                    pendableServiceSet,
    input  wire logic                    systemTickReq,
    input  wire logic [31:0]             swEnableSet,
    input  wire logic [31:0]             swEnableClear,
    input  wire epim_pkg::epim_srcmask_t swPendSet,
    input  wire epim_pkg::epim_srcmask_t swPendClear,
    input  wire logic                    prioWrite,
    input  wire epim_pkg::epim_index_t   prioIndex,
    input  wire epim_pkg::epim_level_t   prioLevel,
    input  wire logic                    excAccept,
    input  wire logic                    excReturn,
    input  wire epim_pkg::epim_vector_t  returnVector,
    output logic                         excValid,
    output epim_pkg::epim_vector_t       excVector,
    output epim_pkg::epim_rank_t         excRank,
    output logic [31:0]                  fetchAddr,
    output epim_pkg::epim_srcmask_t      pendingState,
    output epim_pkg::epim_srcmask_t      activeState,
    output logic [31:0]                  enableState
);
    typedef struct packed {
        logic [1:0]              syncA;
        logic [1:0]              syncB;
        epim_pkg::epim_srcmask_t pend;
        epim_pkg::epim_srcmask_t act;
        logic [31:0]             en;
        epim_pkg::epim_prio_t    prio;
        logic                    resetPend;
        logic                    nmiAct;
        logic                    hfAct;
        logic [1:0]              holdoff;
        logic                    valid;
        epim_pkg::epim_vector_t  vector;
        epim_pkg::epim_rank_t    rank;
        logic [31:0]             addr;
    } epim_state_t;

    epim_state_t s;
    epim_state_t next_s;
    logic                    winValid;
    epim_pkg::epim_index_t   winIndex;
    epim_pkg::epim_level_t   winLevel;
    epim_pkg::epim_srcmask_t cand;
    logic [31:0]             lines;

    function automatic epim_pkg::epim_vector_t idxToVec(
        input epim_pkg::epim_index_t idx);
        case (idx)
            6'h00: idxToVec = `EPIM_VEC_SVC;
            6'h01: idxToVec = `EPIM_VEC_PENDABLE_SERVICE_EXCEPTION;
            6'h02: idxToVec = `EPIM_VEC_SYSTEM_TICK_EXCEPTION;
            default: idxToVec = idx + 6'h0D;
        endcase
    endfunction

    function automatic epim_pkg::epim_index_t vecToIdx(
        input epim_pkg::epim_vector_t vec);
        case (vec)
            `EPIM_VEC_SVC: vecToIdx = 6'h00;
            `EPIM_VEC_PENDABLE_SERVICE_EXCEPTION: vecToIdx = 6'h01;
            `EPIM_VEC_SYSTEM_TICK_EXCEPTION: vecToIdx = 6'h02;
            default: vecToIdx = vec - 6'h0D;
        endcase
    endfunction

    // pending but inactive, disabled do not compete
    assign cand = s.pend & {s.en, 3'h7} & ~s.act;

    epim_arbiter arb (
        .clk      (clk),
        .reset    (reset),
        .cand     (cand),
        .prio     (s.prio),
        .winValid (winValid),
        .winIndex (winIndex),
        .winLevel (winLevel)
    );

    always_comb
    begin
        lines = {spareIrq, 11'h000};
        lines[`EPIM_LINE_BROWNOUT] = brownoutIrq;
        lines[`EPIM_LINE_WATCHDOG] = watchdogIrq;
        lines[`EPIM_LINE_EXT_A] = s.syncA[1];
        lines[`EPIM_LINE_EXT_B] = s.syncB[1];
        lines[`EPIM_LINE_PORT_AB] = (|portAChange) | (|portBChange);
        lines[`EPIM_LINE_PORT_CDEF] = (|portCChange) | (|portDChange)
            | (|portEChange) | (|portFChange);
        lines[`EPIM_LINE_PWM_LOW] = |pwmChannelIrq[3:0];
        lines[`EPIM_LINE_PWM_HIGH] = |pwmChannelIrq[7:4];
        lines[`EPIM_LINE_TIMER0] = timerZeroIrq;
        lines[`EPIM_LINE_TIMER1] = timerOneIrq;
        lines[`EPIM_LINE_TIMER2] = timerTwoIrq;
    end

    always_comb
    begin
        epim_pkg::epim_srcmask_t setMask;
        epim_pkg::epim_srcmask_t clrMask;
        epim_pkg::epim_srcmask_t accMask;
        setMask = '0;
        clrMask = '0;
        accMask = '0;
        next_s = s;
        next_s.syncA = {s.syncA[0], extPinIrqA};
        next_s.syncB = {s.syncB[0], extPinIrqB};
        next_s.en = (s.en & ~swEnableClear) | swEnableSet;
        if (prioWrite && prioIndex < 6'(`EPIM_NUM_SRC))
            next_s.prio[2*prioIndex +: 2] = prioLevel;
        if (excAccept && s.valid)
        begin
            next_s.holdoff = `EPIM_HOLDOFF;
            if (s.vector == `EPIM_VEC_RESET)
                next_s.resetPend = 1'b0;
            else if (s.vector == `EPIM_VEC_NMI)
                next_s.nmiAct = 1'b1;
            else if (s.vector == `EPIM_VEC_HARDFAULT)
                next_s.hfAct = 1'b1;
            else
                accMask[vecToIdx(s.vector)] = 1'b1;
        end
        else if (s.holdoff != 2'h0)
            next_s.holdoff = s.holdoff - 2'h1;
        setMask = ({lines, systemTickReq, pendableServiceSet,
            supervisorCallReq} & ~s.act) | swPendSet;
        clrMask = swPendClear | accMask;
        // A new event wins over a software pend clear in the same cycle, but not over the clear made by an accept.
        next_s.pend = (s.pend & ~clrMask) | (setMask & ~accMask);
        // only accept and return touch active
        next_s.act = s.act | accMask;
        if (excReturn)
        begin
            if (returnVector == `EPIM_VEC_NMI)
                next_s.nmiAct = 1'b0;
            else if (returnVector == `EPIM_VEC_HARDFAULT)
                next_s.hfAct = 1'b0;
            else if (returnVector >= `EPIM_VEC_SVC
                     && returnVector <= `EPIM_VEC_LAST)
                next_s.act[vecToIdx(returnVector)] = 1'b0;
        end
        next_s.valid = 1'b0;
        next_s.vector = '0;
        next_s.rank = '0;
        if (next_s.holdoff != 2'h0)
            next_s.valid = 1'b0;
        else if (s.resetPend)
        begin
            next_s.valid = 1'b1;
            next_s.vector = `EPIM_VEC_RESET;
            next_s.rank = `EPIM_RANK_RESET;
        end
        else if (nmiReq && !s.nmiAct)
        begin
            next_s.valid = 1'b1;
            next_s.vector = `EPIM_VEC_NMI;
            next_s.rank = `EPIM_RANK_NMI;
        end
        else if (hardFaultReq && !s.hfAct)
        begin
            next_s.valid = 1'b1;
            next_s.vector = `EPIM_VEC_HARDFAULT;
            next_s.rank = `EPIM_RANK_HARDFAULT;
        end
        else if (winValid && cand[winIndex])
        begin
            next_s.valid = 1'b1;
            next_s.vector = idxToVec(winIndex);
            next_s.rank = `EPIM_RANK_CFG_BASE + {1'b0, winLevel};
        end
        next_s.addr = `EPIM_TABLE_BASE + {24'h000000, next_s.vector, 2'h0};
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '0;
            s.prio <= {`EPIM_NUM_SRC{`EPIM_PRIO_RESET}};
            s.resetPend <= 1'b1;
            s.addr <= `EPIM_TABLE_BASE;
        end
        else
            s <= next_s;
    end

    assign excValid = s.valid;
    assign excVector = s.vector;
    assign excRank = s.rank;
    assign fetchAddr = s.addr;
    assign pendingState = s.pend;
    assign activeState = s.act;
    assign enableState = s.en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    prio_level_write_a: assert property (
        prioWrite && prioIndex < 6'h23 |=>
        s.prio[2*$past(prioIndex) +: 2] == $past(prioLevel))
        else $error("priority write not stored");
    prio_after_reset_a: assert property (
        $fell(reset) |-> s.prio == '0)
        else $error("priority not zero after reset");
    reset_first_a: assert property (
        s.resetPend && s.holdoff == 2'h0 && !excAccept |=>
        excValid && excVector == 6'h01 && excRank == 3'h0)
        else $error("reset not presented first");
    nmi_outranks_a: assert property (
        nmiReq && !s.nmiAct && !s.resetPend && s.holdoff == 2'h0
        && !excAccept |=> excVector == 6'h02 && excRank == 3'h1)
        else $error("NMI lost to a lower rank");
    cfg_vector_range_a: assert property (
        excValid && excRank >= 3'h3 |-> excVector == 6'h0B
        || excVector == 6'h0E || excVector == 6'h0F
        || (excVector >= 6'h10 && excVector <= 6'h2F))
        else $error("configurable vector out of range");
    brownout_pends_a: assert property (
        brownoutIrq && !s.act[3] && !excAccept |=> s.pend[3])
        else $error("brown-out line did not pend");
    port_ab_pends_a: assert property (
        (|portAChange) && !s.act[7] && !excAccept |=> s.pend[7])
        else $error("port A/B change did not pend");
    active_kept_a: assert property (
        !excReturn |=> (s.act & $past(s.act)) == $past(s.act))
        else $error("active state dropped without return");
    fetch_addr_a: assert property (
        excValid |-> fetchAddr == {24'h000000, excVector, 2'h0})
        else $error("fetch address not vector times four");
endmodule

// ---- testbench/epim_core_model.sv ----
// Behavioural processor core that takes and returns exceptions.
`timescale 1ns/1ps
module epim_core_model (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   gate,
    input  wire logic                   hold,
    input  wire logic                   excValid,
    input  wire epim_pkg::epim_vector_t excVector,
    input  wire epim_pkg::epim_rank_t   excRank,
    input  wire logic [31:0]            fetchAddr,
    output logic                        excAccept,
    output logic                        excReturn,
    output epim_pkg::epim_vector_t      returnVector,
    output logic                        taken,
    output epim_pkg::epim_vector_t      takenVec,
    output epim_pkg::epim_rank_t        takenRank,
    output logic [31:0]                 takenAddr
);
    epim_pkg::epim_vector_t running[$];
    int                     age;
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            excAccept <= 1'b0;
            excReturn <= 1'b0;
            returnVector <= 6'h00;
            taken <= 1'b0;
            takenVec <= 6'h00;
            takenRank <= 3'h0;
            takenAddr <= 32'h00000000;
            age <= 0;
            running.delete();
        end
        else
        begin
            excAccept <= gate && excValid && !excAccept;
            taken <= excAccept && excValid;
            excReturn <= 1'b0;
            if (excAccept && excValid)
            begin
                takenVec <= excVector;
                takenRank <= excRank;
                takenAddr <= fetchAddr;
                running.push_back(excVector);
            end
            // Hold models a long handler; otherwise handlers end quickly.
            if (running.size() > 0 && !hold && !excReturn && age >= 3)
            begin
                excReturn <= 1'b1;
                returnVector <= running.pop_back();
                age <= 0;
            end
            else
            begin
                // The vector is meaningless between returns, so it toggles.
                returnVector <= ~returnVector;
                age <= age + 1;
            end
        end
    end
endmodule

// ---- testbench/tb_epim_controller.sv ----
// Self-checking bench for the exception priority and interrupt map.
`timescale 1ns/1ps
module tb_epim_controller;
    logic                    clk, reset, gate, hold;
    logic                    brownoutIrq, watchdogIrq, extPinIrqA, extPinIrqB;
    logic                    timerZeroIrq, timerOneIrq, timerTwoIrq, nmiReq;
    logic                    hardFaultReq, supervisorCallReq, systemTickReq;
    logic                    pendableServiceSet, prioWrite, excAccept;
    logic                    excReturn, excValid, taken;
    logic [15:0]             portAChange, portCChange, portDChange;
    logic [15:0]             portEChange;
    logic [13:0]             portBChange;
    logic [3:0]              portFChange;
    logic [7:0]              pwmChannelIrq;
    logic [20:0]             spareIrq, spareVal;
    logic [31:0]             swEnableSet, swEnableClear, fetchAddr;
    logic [31:0]             takenAddr, enableState;
    epim_pkg::epim_srcmask_t swPendSet, swPendClear, pendingState, activeState;
    epim_pkg::epim_srcmask_t want;
    epim_pkg::epim_index_t   prioIndex;
    epim_pkg::epim_level_t   prioLevel;
    epim_pkg::epim_vector_t  excVector, returnVector, takenVec;
    epim_pkg::epim_rank_t    excRank, takenRank;
    int                      numErrors, numChecks, lvl, level[35], expq[$];
    epim_controller DUT (.clk, .reset, .brownoutIrq, .watchdogIrq, .extPinIrqA,
        .extPinIrqB, .portAChange, .portBChange, .portCChange, .portDChange,
        .portEChange, .portFChange, .pwmChannelIrq, .timerZeroIrq, .timerOneIrq,
        .timerTwoIrq, .spareIrq, .nmiReq, .hardFaultReq, .supervisorCallReq,
        .pendableServiceSet, .systemTickReq, .swEnableSet, .swEnableClear,
        .swPendSet, .swPendClear, .prioWrite, .prioIndex, .prioLevel,
        .excAccept, .excReturn, .returnVector, .excValid, .excVector, .excRank,
        .fetchAddr, .pendingState, .activeState, .enableState);
    epim_core_model core (.clk, .reset, .gate, .hold, .excValid, .excVector,
        .excRank, .fetchAddr, .excAccept, .excReturn, .returnVector, .taken,
        .takenVec, .takenRank, .takenAddr);
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, exp, input string what);
        numChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("wrong value at %0t: %s %0h not %0h",
                     $time, what, got, exp);
        end
    endtask
    task automatic printVerdict();
        if (numErrors == 0 && numChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic int vecOf(int s);
        return s == 0 ? 11 : s == 1 ? 14 : s == 2 ? 15 : s + 13;
    endfunction
    task automatic idle();
        {brownoutIrq, watchdogIrq, extPinIrqA, extPinIrqB, timerZeroIrq,
         timerOneIrq, timerTwoIrq, supervisorCallReq, pendableServiceSet,
         systemTickReq, prioWrite, prioIndex, prioLevel} <= '0;
        {portAChange, portBChange, portCChange, portDChange, portEChange,
         portFChange, pwmChannelIrq, spareIrq} <= '0;
        {swEnableSet, swEnableClear, swPendSet, swPendClear} <= '0;
    endtask
    task automatic swPulse(input logic [31:0] es, ec,
                           input epim_pkg::epim_srcmask_t ps, pc);
        @(posedge clk);
        swEnableSet <= es;
        swEnableClear <= ec;
        swPendSet <= ps;
        swPendClear <= pc;
        @(posedge clk);
        idle();
        repeat (3) @(posedge clk);
    endtask
    task automatic pulseAll();
        spareVal = 21'($urandom) | 21'h000001;
        @(posedge clk);
        {brownoutIrq, watchdogIrq, extPinIrqA, extPinIrqB, timerZeroIrq,
         timerOneIrq, timerTwoIrq, supervisorCallReq, pendableServiceSet,
         systemTickReq} <= 10'h3FF;
        portAChange <= 16'h0001 << ($urandom % 16);
        portBChange <= 14'h0001 << ($urandom % 14);
        portCChange <= 16'h0001 << ($urandom % 16);
        portDChange <= 16'h0001 << ($urandom % 16);
        portEChange <= 16'h0001 << ($urandom % 16);
        portFChange <= 4'h1 << ($urandom % 4);
        pwmChannelIrq <= 8'h11 << ($urandom % 4);
        spareIrq <= spareVal;
        @(posedge clk);
        idle();
        want = {spareVal, 14'h3FFF};
        repeat (8) @(posedge clk);
    endtask
    task automatic queueWanted();
        int bestS, bestKey, key;
        while (want != '0)
        begin
            bestKey = 1000;
            bestS = 0;
            for (int s = 0; s < 35; s++)
            begin
                key = level[s] * 64 + vecOf(s);
                if (want[s] && key < bestKey)
                begin
                    bestKey = key;
                    bestS = s;
                end
            end
            expq.push_back(vecOf(bestS));
            want[bestS] = 1'b0;
        end
    endtask
    task automatic runExpect();
        int n, v, r;
        @(posedge clk);
        gate <= 1'b1;
        while (expq.size() > 0)
        begin
            v = expq.pop_front();
            r = v < 4 ? v - 1 : 3 + level[v == 11 ? 0 : v == 14 ? 1 :
                                         v == 15 ? 2 : v - 13];
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end
            while (taken !== 1'b1 && n < 80);
            check(taken, 32'h1, "taken");
            if (taken !== 1'b1)
                printVerdict();
            check(takenVec, v, "vector");
            check(takenRank, r, "rank");
            check(takenAddr, 32'(4 * v), "fetch address");
            @(posedge clk);
            if (v == 2)
                nmiReq <= 1'b0;
            if (v == 3)
                hardFaultReq <= 1'b0;
        end
        gate <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    initial
    begin
        void'($urandom(32'h6E5EA2B8));
        numErrors = 0;
        numChecks = 0;
        {gate, hold, nmiReq, hardFaultReq} = 4'h0;
        idle();
        foreach (level[s])
            level[s] = 0;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        expq = '{1};
        runExpect();
        swPulse(32'hFFFFFFFF, 32'h0, '0, '0);
        check(enableState, 32'hFFFFFFFF, "enables set");
        pulseAll();
        queueWanted();
        runExpect();
        // four levels per slot; slot 35 is ignored
        for (int s = 0; s < 36; s++)
        begin
            @(posedge clk);
            lvl = $urandom % 4;
            prioWrite <= 1'b1;
            prioIndex <= 6'(s);
            prioLevel <= 2'(lvl);
            if (s < 35)
                level[s] = lvl;
        end
        @(posedge clk);
        idle();
        nmiReq <= 1'b1;
        hardFaultReq <= 1'b1;
        pulseAll();
        expq = '{2, 3};
        queueWanted();
        runExpect();
        swPulse(32'h0, 32'h2, '0, '0);
        check(enableState, 32'hFFFFFFFD, "enable cleared");
        @(posedge clk);
        watchdogIrq <= 1'b1;
        gate <= 1'b1;
        @(posedge clk);
        watchdogIrq <= 1'b0;
        repeat (10) @(negedge clk);
        check(pendingState[4], 1'b1, "disabled pending");
        check(excValid, 1'b0, "disabled presented");
        @(posedge clk);
        hold <= 1'b1;
        // The core stays away until runExpect is watching for the take.
        gate <= 1'b0;
        swPulse(32'h2, 32'h0, '0, '0);
        expq = '{17};
        runExpect();
        swPulse(32'h0, 32'h2, 35'h10, '0);
        check(pendingState[4], 1'b1, "pending set");
        swPulse(32'h0, 32'h0, '0, 35'h10);
        check(activeState[4], 1'b1, "active kept");
        check(pendingState[4], 1'b0, "pending cleared");
        hold <= 1'b0;
        repeat (10) @(posedge clk);
        check(activeState[4], 1'b0, "active ended");
        swPulse(32'h0, 32'h0, 35'h1, '0);
        expq = '{11};
        runExpect();
        printVerdict();
    end
endmodule
